// file: rtl/dpb_gate_seq.sv
// Break-before-make gate sequencer for one channel
module dpb_gate_seq (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Requests from the cycle logic
    input wire logic highReq,
    input wire logic lowReq,
    // Sensed power stage
    input wire logic switchNodeLow,
    input wire logic lowGateSense,
    // Gate drives
    output logic highGate,
    output logic lowGate
);
    logic highGate_next;
    logic lowGate_next;

    // Dead time follows the sensed nodes, so it adapts to the MOSFETs
    always_comb begin
        highGate_next = highReq & ~lowGate & ~lowGateSense;
        lowGate_next = lowReq & ~highGate & switchNodeLow;
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            highGate <= 1'b0;
            lowGate <= 1'b0;
        end else begin
            highGate <= highGate_next;
            lowGate <= lowGate_next;
        end
    end

    crossCond_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        !(highGate && lowGate)) else $error("both gates on");
    lowWait_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        $rose(highGate) |-> !$past(lowGate) && !$past(lowGateSense))
        else $error("high gate rose before low side off");
endmodule : dpb_gate_seq

// file: rtl/dpb_params.svh
// Constants of the dual-phase buck timing block
`ifndef DPB_PARAMS_SVH
`define DPB_PARAMS_SVH

`define DPB_CLK_HZ 40000000
`define DPB_CLK_KHZ (`DPB_CLK_HZ / 1000)
`define DPB_F_GND_KHZ 300
`define DPB_F_RAIL_KHZ 600
`define DPB_F_MIN_KHZ 200
`define DPB_F_MAX_KHZ 1500
`define DPB_PER_GND (`DPB_CLK_KHZ / `DPB_F_GND_KHZ)
`define DPB_PER_RAIL (`DPB_CLK_KHZ / `DPB_F_RAIL_KHZ)
`define DPB_PER_MAX (`DPB_CLK_KHZ / `DPB_F_MIN_KHZ)
`define DPB_PER_MIN ((`DPB_CLK_KHZ + `DPB_F_MAX_KHZ - 1) / `DPB_F_MAX_KHZ)
`define DPB_SYNC_DLY_NS 100
`define DPB_SYNC_DLY ((`DPB_SYNC_DLY_NS * (`DPB_CLK_HZ / 1000000)) / 1000)
`define DPB_LOSS_PERIODS 2
`define DPB_PER_W 8
`define DPB_LOSS_W 10

`endif

// file: rtl/dpb_pkg.sv
// Types of the dual-phase buck timing block
package dpb_pkg;
    typedef enum logic [1:0] {
        CH_IDLE,
        CH_ON,
        CH_OFF
    } dpb_chan_state_t;
endpackage : dpb_pkg

// file: rtl/dpb_pwm_timing.sv
// Oscillator, mode, sync and cycle timing of the dual-phase buck controller
`include "dpb_params.svh"

module dpb_pwm_timing
    import dpb_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Frequency set pin straps
    input wire logic setPinAToGround,
    input wire logic setPinAToRail,
    input wire logic [7:0] freqSetResistorPeriod,
    // Mode and sync pin
    input wire logic syncPin,
    // Analog comparators per channel
    input wire logic [1:0] errAmpAboveSkip,
    input wire logic [1:0] pwmCompTrip,
    input wire logic [1:0] zeroCross,
    // Sensed power stage per channel
    input wire logic [1:0] switchNodeLow,
    input wire logic [1:0] lowGateSense,
    // Gate drives
    output logic highSideGateA,
    output logic highSideGateB,
    output logic [1:0] lowSideGate,
    // Current sense timing
    output logic [1:0] valleySample,
    output logic [1:0] rampStart,
    // Status
    output logic forcedPwm,
    output logic syncLocked
);
    localparam int DLY = `DPB_SYNC_DLY;
    localparam int PW = `DPB_PER_W;
    localparam int LW = `DPB_LOSS_W;

    // Oscillator, sync and mode state
    logic [PW-1:0] period_reg, period_next;
    logic [PW-1:0] phase_reg, phase_next;
    logic [LW-1:0] loss_reg, loss_next;
    logic locked_reg, locked_next;
    logic syncPrev_reg, syncPrev_next;
    logic nextCh_reg, nextCh_next;
    logic [DLY-1:0] edgeDly_reg, edgeDly_next;
    logic [DLY-1:0] chDly_reg, chDly_next;
    logic [1:0] start_reg, start_next;
    logic forced_reg, forced_next;
    logic [PW-1:0] half;
    logic [PW-1:0] resPeriod;
    logic [LW-1:0] lossLimit;
    logic syncRise;
    logic edgeCh;
    logic boundary;
    logic lossHit;

    always_comb begin
        half = {1'b0, period_reg[PW-1:1]};
        syncRise = syncPin & ~syncPrev_reg;
        syncPrev_next = syncPin;
        boundary = ~locked_reg & (phase_reg == period_reg - 8'h01);
        lossLimit = LW'(`DPB_LOSS_PERIODS) * {2'h0, period_reg};
        // Any sync period up to 2x the oscillator period beats this limit
        lossHit = locked_reg & (loss_reg >= lossLimit);

        // Out-of-range resistor settings are held at the range ends
        if (freqSetResistorPeriod < PW'(`DPB_PER_MIN)) begin
            resPeriod = PW'(`DPB_PER_MIN);
        end else if (freqSetResistorPeriod > PW'(`DPB_PER_MAX)) begin
            resPeriod = PW'(`DPB_PER_MAX);
        end else begin
            resPeriod = freqSetResistorPeriod;
        end
        if (setPinAToGround) begin
            period_next = PW'(`DPB_PER_GND);
        end else if (setPinAToRail) begin
            period_next = PW'(`DPB_PER_RAIL);
        end else begin
            period_next = resPeriod;
        end

        locked_next = locked_reg;
        if (syncRise) begin
            locked_next = 1'b1;
        end else if (lossHit) begin
            locked_next = 1'b0;
        end

        loss_next = (syncRise || !locked_reg) ? '0 : loss_reg + 10'h001;

        // Oscillator held in reset while the sync clock rules
        if (syncRise || locked_reg) begin
            phase_next = '0;
        end else if (boundary) begin
            phase_next = '0;
        end else begin
            phase_next = phase_reg + 8'h01;
        end

        // First edge goes to whichever channel is nearer its cycle end
        edgeCh = locked_reg ? nextCh_reg : (phase_reg < half);
        nextCh_next = syncRise ? ~edgeCh : nextCh_reg;
        edgeDly_next = {edgeDly_reg[DLY-2:0], syncRise};
        chDly_next = {chDly_reg[DLY-2:0], edgeCh};

        // Internal starts: A at wrap, B half a period later
        start_next[0] = (boundary & ~syncRise)
            | (lossHit & ~syncRise);
        start_next[1] = ~locked_reg & ~syncRise
            & (phase_reg == half - 8'h01);
        // Sync starts: each divided phase clocks one channel
        if (edgeDly_reg[DLY-2]) begin
            start_next[chDly_reg[DLY-2]] = 1'b1;
        end

        // Pin level sampled at each cycle boundary, pull-up keeps PWM
        if (locked_next) begin
            forced_next = 1'b1;
        end else if (boundary || lossHit) begin
            forced_next = syncPin;
        end else begin
            forced_next = forced_reg;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            period_reg <= PW'(`DPB_PER_GND);
            phase_reg <= '0;
            loss_reg <= '0;
            locked_reg <= 1'b0;
            // Idle high, so a pulled-up pin gives no false edge after reset
            syncPrev_reg <= 1'b1;
            nextCh_reg <= 1'b0;
            edgeDly_reg <= '0;
            chDly_reg <= '0;
            start_reg <= 2'h0;
            forced_reg <= 1'b0;
        end else begin
            period_reg <= period_next;
            phase_reg <= phase_next;
            loss_reg <= loss_next;
            locked_reg <= locked_next;
            syncPrev_reg <= syncPrev_next;
            nextCh_reg <= nextCh_next;
            edgeDly_reg <= edgeDly_next;
            chDly_reg <= chDly_next;
            start_reg <= start_next;
            forced_reg <= forced_next;
        end
    end

    assign forcedPwm = forced_reg;
    assign syncLocked = locked_reg;

    // Per-channel cycle state and gate sequencing
    logic [1:0] highGate;
    logic [1:0] lowGate;
    logic [1:0] highReq;
    logic [1:0] lowReq;
    logic [1:0] valley_reg, valley_next;
    logic [1:0] ramp_reg, ramp_next;
    logic [1:0] highPrev_reg, highPrev_next;
    dpb_chan_state_t chState_reg [2];
    dpb_chan_state_t chState_next [2];

    for (genvar c = 0; c < 2; c++) begin : g_chan
        logic skip;

        always_comb begin
            // Light load in skip mode drops the pulse entirely
            skip = ~forced_reg & ~errAmpAboveSkip[c];
            chState_next[c] = chState_reg[c];
            valley_next[c] = 1'b0;
            case (chState_reg[c])
                CH_IDLE: begin
                    if (start_reg[c] && !skip) begin
                        chState_next[c] = CH_ON;
                    end
                end
                CH_ON: begin
                    if (pwmCompTrip[c]) begin
                        chState_next[c] = CH_OFF;
                    end
                end
                CH_OFF: begin
                    if (start_reg[c]) begin
                        valley_next[c] = 1'b1;
                        if (!skip) begin
                            chState_next[c] = CH_ON;
                        end
                    end else if (!forced_reg && zeroCross[c]) begin
                        // DCM only outside forced PWM
                        chState_next[c] = CH_IDLE;
                    end
                end
                default: begin
                    chState_next[c] = CH_IDLE;
                end
            endcase
            highReq[c] = (chState_reg[c] == CH_ON);
            lowReq[c] = (chState_reg[c] == CH_OFF);
            highPrev_next[c] = highGate[c];
            ramp_next[c] = highGate[c] & ~highPrev_reg[c];
        end

        always_ff @(posedge sys_clk or negedge resetn) begin
            if (!resetn) begin
                chState_reg[c] <= CH_IDLE;
                valley_reg[c] <= 1'b0;
                ramp_reg[c] <= 1'b0;
                highPrev_reg[c] <= 1'b0;
            end else begin
                chState_reg[c] <= chState_next[c];
                valley_reg[c] <= valley_next[c];
                ramp_reg[c] <= ramp_next[c];
                highPrev_reg[c] <= highPrev_next[c];
            end
        end

        dpb_gate_seq u_gate (
            .sys_clk(sys_clk),
            .resetn(resetn),
            .highReq(highReq[c]),
            .lowReq(lowReq[c]),
            .switchNodeLow(switchNodeLow[c]),
            .lowGateSense(lowGateSense[c]),
            .highGate(highGate[c]),
            .lowGate(lowGate[c])
        );

        forcedCcm_a: assert property (@(posedge sys_clk) disable iff (!resetn)
            forced_reg && start_reg[c] && chState_reg[c] != CH_ON |=> chState_reg[c] == CH_ON)
            else $error("forced PWM cycle not started");
        skipPulse_a: assert property (@(posedge sys_clk) disable iff (!resetn)
            !forced_reg && !errAmpAboveSkip[c] && start_reg[c] && chState_reg[c] == CH_IDLE
            |=> chState_reg[c] == CH_IDLE)
            else $error("pulse not skipped at light load");
        valleyRamp_a: assert property (@(posedge sys_clk) disable iff (!resetn)
            $rose(highGate[c]) |=> rampStart[c])
            else $error("ramp not started with on time");
        valleyEnd_a: assert property (@(posedge sys_clk) disable iff (!resetn)
            valleySample[c] |-> $past(chState_reg[c]) == CH_OFF && $past(start_reg[c]))
            else $error("valley sample outside off end");
    end

    assign highSideGateA = highGate[0];
    assign highSideGateB = highGate[1];
    assign lowSideGate = lowGate;
    assign valleySample = valley_reg;
    assign rampStart = ramp_reg;

    // Cycles since channel A start, for the interleave check
    logic [PW-1:0] sinceA;
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            sinceA <= '0;
        end else begin
            sinceA <= start_reg[0] ? 8'h01 : sinceA + 8'h01;
        end
    end

    interleaveB_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        start_reg[1] && !locked_reg && $past(start_reg[0], 2) == 1'b0 && sinceA != 8'h00
        && $stable(period_reg) |-> sinceA == half)
        else $error("channel B not half a period after A");
    syncDelay_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        syncRise |-> ##4 (start_reg != 2'h0))
        else $error("sync start not 100 ns after edge");
    lockEdge_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        !locked_reg && syncRise |=> locked_reg && phase_reg == '0)
        else $error("first sync edge did not take control");
    syncPwm_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        locked_reg |-> forced_reg)
        else $error("sync mode not in forced PWM");
    alternate_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        locked_reg && syncRise |=> nextCh_reg != $past(nextCh_reg))
        else $error("sync edges not alternating channels");
    lossFall_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        lossHit && !syncRise |=> !locked_reg ##0 start_reg[0])
        else $error("no fallback to oscillator on sync loss");
    modeFollow_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        boundary && !syncRise |=> forced_reg == $past(syncPin))
        else $error("mode pin not applied at cycle boundary");
    clampRange_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        period_reg >= PW'(`DPB_PER_MIN) && period_reg <= PW'(`DPB_PER_MAX))
        else $error("oscillator period out of range");
    strapGnd_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        setPinAToGround |=> period_reg == PW'(`DPB_PER_GND))
        else $error("grounded set pin not at low frequency");
    oneStart_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        locked_reg |-> start_reg != 2'h3)
        else $error("both channels started on one sync edge");

    lockSeen_c: cover property (@(posedge sys_clk) disable iff (!resetn)
        !locked_reg ##1 locked_reg);
    lossSeen_c: cover property (@(posedge sys_clk) disable iff (!resetn)
        locked_reg ##1 !locked_reg);
    dcmIdle_c: cover property (@(posedge sys_clk) disable iff (!resetn)
        chState_reg[0] == CH_OFF ##1 chState_reg[0] == CH_IDLE);
    modeSwap_c: cover property (@(posedge sys_clk) disable iff (!resetn)
        !locked_reg && forced_reg ##1 !forced_reg);
    valleyCcm_c: cover property (@(posedge sys_clk) disable iff (!resetn)
        valleySample[0] && forced_reg);
endmodule : dpb_pwm_timing

// file: tb/dpb_stage_model.sv
// Power stage and sync clock source facing the timing block
module dpb_stage_model #(
    parameter int SYNC_HALF = 50
) (
    // Clock
    input wire logic sys_clk,
    // Gate drives and sync control
    input wire logic [1:0] highGate,
    input wire logic [1:0] lowGate,
    input wire logic syncOn,
    input wire logic pinLevel,
    // Senses and sync pin
    output logic [1:0] switchNodeLow,
    output logic [1:0] lowGateSense,
    output logic [1:0] pwmCompTrip,
    output logic [1:0] zeroCross,
    output logic syncPin
);
    timeunit 1ns;
    timeprecision 100ps;
    int onCnt [2];
    int offCnt [2];
    int syncCnt = 0;
    logic syncClk = 1'b0;
    initial begin
        switchNodeLow = 2'h3;
        lowGateSense = 2'h0;
        pwmCompTrip = 2'h0;
        zeroCross = 2'h0;
        onCnt = '{0, 0};
        offCnt = '{0, 0};
    end
    // Sync period 2*SYNC_HALF, 0.75x the grounded-strap oscillator period
    always @(posedge sys_clk) begin
        syncCnt <= (syncCnt + 1) % SYNC_HALF;
        if (syncOn && syncCnt == SYNC_HALF - 1) begin
            syncClk <= ~syncClk;
        end
    end
    // Stopped clock leaves the pin at the level the board gives it
    assign syncPin = syncOn ? syncClk : pinLevel;
    // Senses lag the gates by a cycle, so the block must wait for them
    always @(posedge sys_clk) begin
        switchNodeLow <= ~highGate;
        lowGateSense <= lowGate;
        for (int c = 0; c < 2; c++) begin
            onCnt[c] <= highGate[c] ? onCnt[c] + 1 : 0;
            offCnt[c] <= lowGate[c] ? offCnt[c] + 1 : 0;
            pwmCompTrip[c] <= onCnt[c] >= 7;
            zeroCross[c] <= offCnt[c] >= 30;
        end
    end
endmodule : dpb_stage_model

// file: tb/test_dpb_pwm_timing.sv
// Self-checking bench of the dual-phase buck timing block
`include "dpb_params.svh"

module test_dpb_pwm_timing;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int PG = `DPB_PER_GND;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic gnd = 1'b1;
    logic rail = 1'b0;
    logic [7:0] resPer = 8'h00;
    logic pinLevel = 1'b0;
    logic syncOn = 1'b0;
    logic [1:0] aboveSkip = 2'h3;
    logic syncPin, hiA, hiB, forcedPwm, syncLocked, syncPrev;
    logic [1:0] snLow, lgSense, trip, zc, lowG, valley, ramp;
    int n_mismatch = 0;
    int checks = 0;
    int sinceValley = 0;
    int sinceSync = 0;

    initial begin
        forever #12.5 sys_clk = ~sys_clk;
    end

    dpb_pwm_timing dpb_pwm_timing_i (.sys_clk(sys_clk), .resetn(resetn),
        .setPinAToGround(gnd), .setPinAToRail(rail), .freqSetResistorPeriod(resPer),
        .syncPin(syncPin), .errAmpAboveSkip(aboveSkip), .pwmCompTrip(trip),
        .zeroCross(zc), .switchNodeLow(snLow), .lowGateSense(lgSense),
        .highSideGateA(hiA), .highSideGateB(hiB), .lowSideGate(lowG),
        .valleySample(valley), .rampStart(ramp), .forcedPwm(forcedPwm),
        .syncLocked(syncLocked));

    dpb_stage_model dpb_stage_model_i (.sys_clk(sys_clk), .highGate({hiB, hiA}),
        .lowGate(lowG), .syncOn(syncOn), .pinLevel(pinLevel), .switchNodeLow(snLow),
        .lowGateSense(lgSense), .pwmCompTrip(trip), .zeroCross(zc), .syncPin(syncPin));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    task automatic finish_test;
        if (n_mismatch == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : finish_test

    always @(posedge sys_clk) begin
        syncPrev <= syncPin;
        sinceSync <= (syncPin & ~syncPrev) ? 0 : sinceSync + 1;
        sinceValley <= valley[0] ? 0 : sinceValley + 1;
        if (resetn) begin
            check((hiA & lowG[0]) | (hiB & lowG[1]), 0);
        end
    end

    function automatic logic sel(input int k);
        return k == 0 ? hiA : k == 1 ? hiB : k == 2 ? forcedPwm : syncLocked;
    endfunction : sel

    // Cycles to the next rise of a high gate; lim when none comes
    task automatic to_rise(input int ch, input int lim, output int n);
        logic last;
        n = 0;
        last = sel(ch);
        @(negedge sys_clk);
        while (n < lim - 1 && !(sel(ch) === 1'b1 && last === 1'b0)) begin
            last = sel(ch);
            n++;
            @(negedge sys_clk);
        end
        n++;
    endtask : to_rise

    task automatic wait_lvl(input int k, input logic v, input int lim, output int n);
        n = 0;
        while (sel(k) !== v && n < lim) begin
            @(negedge sys_clk);
            n++;
        end
    endtask : wait_lvl

    task automatic period(input int ch, input int exp);
        int n;
        // First cycles after a change may start from idle, so skip the first two
        repeat (3) begin
            to_rise(ch, 2 * exp + 10, n);
        end
        check(n, exp);
    endtask : period

    task automatic do_reset(input logic g, input logic r, input logic [7:0] p);
        @(posedge sys_clk);
        resetn <= 1'b0;
        gnd <= g;
        rail <= r;
        resPer <= p;
        repeat (2) @(posedge sys_clk);
        resetn <= 1'b1;
    endtask : do_reset

    task automatic t_straps;
        int n;
        period(0, PG);
        @(negedge sys_clk);
        check(ramp[0], 1);
        to_rise(1, PG, n);
        @(negedge sys_clk);
        check(ramp[1], 1);
        check(n + 1 >= PG / 2 - 1 && n + 1 <= PG / 2 + 1, 1);
        do_reset(1'b0, 1'b1, 8'h00);
        period(0, `DPB_PER_RAIL);
        do_reset(1'b0, 1'b0, 8'h0A);
        period(0, `DPB_PER_MIN);
        check(sinceValley <= 4, 1);
        do_reset(1'b0, 1'b0, 8'hFF);
        period(1, `DPB_PER_MAX);
        do_reset(1'b1, 1'b0, 8'h00);
    endtask : t_straps

    task automatic t_mode_skip;
        int n;
        @(posedge sys_clk) pinLevel <= 1'b1;
        wait_lvl(2, 1'b1, 2 * PG, n);
        check(n < 2 * PG, 1);
        wait_lvl(3, 1'b0, 3 * PG, n);
        to_rise(0, 2 * PG, n);
        repeat (60) @(negedge sys_clk);
        check(lowG[0], 1);
        @(posedge sys_clk) pinLevel <= 1'b0;
        wait_lvl(2, 1'b0, 2 * PG, n);
        check(n < 2 * PG, 1);
        to_rise(0, 2 * PG, n);
        repeat (60) @(negedge sys_clk);
        check(lowG[0], 0);
        @(posedge sys_clk) aboveSkip <= 2'h0;
        repeat (PG) @(negedge sys_clk);
        to_rise(0, 3 * PG, n);
        check(n, 3 * PG);
        @(posedge sys_clk) aboveSkip <= 2'h3;
        to_rise(0, 2 * PG, n);
        check(n < 2 * PG, 1);
    endtask : t_mode_skip

    task automatic t_sync_loss;
        int n;
        @(posedge sys_clk) syncOn <= 1'b1;
        wait_lvl(3, 1'b1, 120, n);
        check(forcedPwm, 1);
        period(0, 200);
        check(sinceSync >= 4 && sinceSync <= 9, 1);
        to_rise(1, 300, n);
        check(n, 100);
        check(sinceSync >= 4 && sinceSync <= 9, 1);
        @(posedge sys_clk);
        pinLevel <= 1'b1;
        syncOn <= 1'b0;
        wait_lvl(3, 1'b0, 3 * PG, n);
        check(n <= 2 * PG + 2, 1);
        check(forcedPwm, 1);
        period(0, PG);
    endtask : t_sync_loss

    initial begin
        repeat (8) @(posedge sys_clk);
        check({hiA, hiB, lowG, valley, ramp, forcedPwm, syncLocked}, 0);
        resetn <= 1'b1;
        t_straps();
        t_mode_skip();
        t_sync_loss();
        finish_test();
    end

    initial begin
        #(20000 * 25);
        n_mismatch++;
        finish_test();
    end
endmodule : test_dpb_pwm_timing
